// File: verilog/comm_glue_pkg.sv
// Package for the communication glue block: register map, field positions,
// reset values and port-select encodings.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
`default_nettype none
package comm_glue_pkg;
  // ==========================================
  // Register port map (software side)
  // ==========================================
  localparam int ADDR_W = 8;                 // Register port address width
  localparam int DATA_W = 8;                 // Register port data width
  localparam logic [7:0] OFF_LINE_CTRL = 8'h00;   // Line-unit control
  localparam logic [7:0] OFF_COMM_CTRL = 8'h01;   // Communication control
  localparam logic [7:0] OFF_STATUS = 8'h02;      // Read-only line status
  localparam logic [7:0] OFF_STRB_STAT = 8'h03;   // Read-only strobe decode status
  // ==========================================
  // Line-unit control fields
  // ==========================================
  localparam int LC_CHAR9 = 0;               // 9-bit characters when set
  localparam int LC_STD_HI = 1;              // High-rate standard when set
  localparam int LC_VOICE = 2;               // Voice usage when set
  localparam int LC_ANSWER = 3;              // Answer role when set
  localparam int LC_OFFHOOK = 4;             // Off-hook relay drive
  localparam logic [7:0] LINE_CTRL_RST = 8'h00;
  // ==========================================
  // Communication control fields
  // ==========================================
  localparam int CC_PSEL0 = 0;               // Port select line 0
  localparam int CC_PSEL1 = 1;               // Port select line 1
  localparam int CC_TREADY = 2;              // Terminal ready
  localparam int CC_RXSPD_LSB = 4;           // Receive speed code, 3 bits
  localparam int RXSPD_W = 3;
  localparam logic [2:0] SPD_600 = 3'h2;     // Codes above this exceed 600 bps
  localparam logic [2:0] SPD_1200 = 3'h3;    // Forced speed code
  localparam logic [7:0] COMM_CTRL_RST = 8'h00;
  // ==========================================
  // Status fields
  // ==========================================
  localparam int ST_CARRIER = 0;             // Merged carrier present
  localparam int ST_PERMIT = 1;              // Send permission present
  localparam int ST_INSTALLED = 2;           // Line unit installed
  localparam int ST_OFFHOOK = 3;             // Line unit reports off hook
  localparam int ST_SETREADY = 4;            // Host data set ready
  localparam int ST_FORCED = 5;              // Speed forced to 1200
  // ==========================================
  // Port select encodings
  // ==========================================
  typedef enum logic [1:0] {PORT_HOST = 2'h0, PORT_LOOP = 2'h2, PORT_LINE = 2'h3, PORT_NONE = 2'h1} port_t;
endpackage
`default_nettype wire

// File: verilog/strobe_if.sv
// Interface carrying decoded register strobes between decoder and core.
// Assumes all members are sampled on the common clock.
`default_nettype none
interface strobe_if;
  logic [3:0] ctrl_wr;   // One-hot control register write selects
  logic [3:0] ctrl_rd;   // One-hot control register read selects
  logic [3:0] sc_reg;    // Serial controller register index
  logic sc_wr;           // Serial controller write
  logic sc_rd;           // Serial controller read
  modport dec (output ctrl_wr, ctrl_rd, sc_reg, sc_wr, sc_rd);
  modport core (input ctrl_wr, ctrl_rd, sc_reg, sc_wr, sc_rd);
endinterface
`default_nettype wire

// File: verilog/ctrl_register_decoder.sv
// Address decoder for control registers and serial controller registers.
// Assumes latched address lines and active-low strobes are synchronous.
`default_nettype none
module ctrl_register_decoder
  import comm_glue_pkg::*;
(
  input wire logic latched_addr_bit1,
  input wire logic latched_addr_bit2,
  input wire logic latched_addr_bit3,
  input wire logic latched_addr_bit4,
  input wire logic latched_addr_bit5,
  input wire logic low_byte_write_n,
  input wire logic ctrl_read_strobe_n,
  input wire logic decoder_enable_n,
  input wire logic sc_write_n,
  input wire logic sc_read_n,
  input wire logic serial_ctrl_select_n,
  strobe_if.dec st
);
  // ==========================================
  // Decode helper
  // ==========================================
  // One-hot from two address bits
  function automatic logic [3:0] onehot2(input logic [1:0] a);
    onehot2 = 4'h1 << a;
  endfunction

  // ==========================================
  // Combinational decode
  // ==========================================
  // Control selects only while the enable is low
  always_comb begin
    st.ctrl_wr = 4'h0;
    st.ctrl_rd = 4'h0;
    if (!decoder_enable_n && !low_byte_write_n) begin
      st.ctrl_wr = onehot2({latched_addr_bit2, latched_addr_bit1});
    end else if (!decoder_enable_n && !ctrl_read_strobe_n) begin
      st.ctrl_rd = onehot2({latched_addr_bit2, latched_addr_bit1});
    end
    st.sc_reg = {latched_addr_bit5, latched_addr_bit4, latched_addr_bit3, latched_addr_bit2};
    st.sc_wr = !sc_write_n && !serial_ctrl_select_n;
    st.sc_rd = !sc_read_n && !serial_ctrl_select_n;
  end
endmodule
`default_nettype wire

// File: verilog/comm_dataset_control_glue.sv
// Communication section glue: control registers, serial controller
// selects, modem handshake steering and register port.
// Assumes synchronous inputs on mclk_i and a one-cycle strobe register port.
//
// The address map and the address-and-strobe port are this design's own decisions.
`default_nettype none
module comm_dataset_control_glue
  import comm_glue_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Latched CPU address and strobes
  input wire logic latched_addr_bit1_i,
  input wire logic latched_addr_bit2_i,
  input wire logic latched_addr_bit3_i,
  input wire logic latched_addr_bit4_i,
  input wire logic latched_addr_bit5_i,
  input wire logic low_byte_write_n_i,
  input wire logic ctrl_read_strobe_n_i,
  input wire logic decoder_enable_n_i,
  input wire logic sc_write_n_i,
  input wire logic sc_read_n_i,
  input wire logic serial_ctrl_select_n_i,
  // Decoded selects
  output logic [3:0] ctrl_wr_sel_n_o,
  output logic [3:0] ctrl_rd_sel_n_o,
  output logic [3:0] sc_reg_o,
  output logic sc_wr_n_o,
  output logic sc_rd_n_o,
  // Serial controller events
  input wire logic host_rx_ready_i,
  input wire logic host_tx_empty_i,
  output logic host_rx_irq_n_o,
  output logic host_tx_irq_n_o,
  // Host / external set
  input wire logic host_send_permit_n_i,
  input wire logic host_set_ready_n_i,
  input wire logic ext_set_carrier_n_i,
  input wire logic ext_set_speed_force_n_i,
  output logic host_term_ready_n_o,
  output logic high_rate_select_n_o,
  // Integral line unit
  input wire logic int_set_carrier_n_i,
  input wire logic int_set_send_permit_n_i,
  input wire logic int_set_installed_n_i,
  input wire logic int_set_speed_force_n_i,
  input wire logic int_set_offhook_i,
  output logic char_length_sel_o,
  output logic standard_select_o,
  output logic line_usage_sel_n_o,
  output logic originate_answer_sel_o,
  output logic offhook_drive_o,
  // Steered results
  output logic merged_carrier_n_o,
  output logic send_permit_n_o,
  output logic port_select0_o,
  output logic port_select1_o,
  output logic [RXSPD_W-1:0] eff_speed_o
);
  // ==========================================
  // Decoder instance
  // ==========================================
  strobe_if st ();  // Decoded strobes

  ctrl_register_decoder u_dec (
    .latched_addr_bit1(latched_addr_bit1_i),
    .latched_addr_bit2(latched_addr_bit2_i),
    .latched_addr_bit3(latched_addr_bit3_i),
    .latched_addr_bit4(latched_addr_bit4_i),
    .latched_addr_bit5(latched_addr_bit5_i),
    .low_byte_write_n(low_byte_write_n_i),
    .ctrl_read_strobe_n(ctrl_read_strobe_n_i),
    .decoder_enable_n(decoder_enable_n_i),
    .sc_write_n(sc_write_n_i),
    .sc_read_n(sc_read_n_i),
    .serial_ctrl_select_n(serial_ctrl_select_n_i),
    .st(st)
  );

  // ==========================================
  // State
  // ==========================================
  typedef struct packed {
    logic [DATA_W-1:0] line_ctrl;   // Line-unit control register
    logic [DATA_W-1:0] comm_ctrl;   // Communication control register
    logic [DATA_W-1:0] rdata;       // Read data
    logic [3:0] wr_sel_n;           // Registered control write selects
    logic [3:0] rd_sel_n;           // Registered control read selects
    logic [3:0] sc_reg;             // Registered controller index
    logic sc_wr_n;                  // Registered controller write
    logic sc_rd_n;                  // Registered controller read
    logic rx_irq_n;                 // Receive interrupt
    logic tx_irq_n;                 // Transmit interrupt
    logic term_ready_n;             // Terminal ready
    logic spd_sel_n;                // Speed select
    logic carrier_n;                // Merged carrier
    logic permit_n;                 // Send permit
    logic forced;                   // Speed forced
    logic [RXSPD_W-1:0] speed;      // Effective speed code
  } state_t;

  state_t q;       // Current state
  state_t next_q;  // Next state

  // Port selection from control bits
  port_t port;
  assign port = port_t'({q.comm_ctrl[CC_PSEL1], q.comm_ctrl[CC_PSEL0]});

  // ==========================================
  // Next-state logic
  // ==========================================
  // Register writes, reads and line steering
  always_comb begin
    logic ext_cd_n;       // External carrier after blocking
    logic [RXSPD_W-1:0] cfg_speed;  // Configured speed
    ext_cd_n = 1'b1;
    cfg_speed = q.comm_ctrl[CC_RXSPD_LSB +: RXSPD_W];
    next_q = q;
    // Software writes
    if (reg_wr_i) begin
      if (reg_addr_i == OFF_LINE_CTRL) begin
        next_q.line_ctrl = reg_wdata_i;
      end else if (reg_addr_i == OFF_COMM_CTRL) begin
        next_q.comm_ctrl = reg_wdata_i;
      end
    end
    // Read data, valid the cycle after the strobe only
    next_q.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == OFF_LINE_CTRL) begin
        next_q.rdata = q.line_ctrl;
      end else if (reg_addr_i == OFF_COMM_CTRL) begin
        next_q.rdata = q.comm_ctrl;
      end else if (reg_addr_i == OFF_STATUS) begin
        next_q.rdata[ST_CARRIER] = !q.carrier_n;
        next_q.rdata[ST_PERMIT] = !q.permit_n;
        next_q.rdata[ST_INSTALLED] = !int_set_installed_n_i;
        next_q.rdata[ST_OFFHOOK] = int_set_offhook_i;
        next_q.rdata[ST_SETREADY] = !host_set_ready_n_i;
        next_q.rdata[ST_FORCED] = q.forced;
      end else if (reg_addr_i == OFF_STRB_STAT) begin
        next_q.rdata = {~q.rd_sel_n, ~q.wr_sel_n};
      end
    end
    // Decoded select outputs, active low
    next_q.wr_sel_n = ~st.ctrl_wr;
    next_q.rd_sel_n = ~st.ctrl_rd;
    next_q.sc_reg = st.sc_reg;
    next_q.sc_wr_n = !st.sc_wr;
    next_q.sc_rd_n = !st.sc_rd;
    // Host interrupts from controller events
    next_q.rx_irq_n = !host_rx_ready_i;
    next_q.tx_irq_n = !host_tx_empty_i;
    next_q.term_ready_n = !q.comm_ctrl[CC_TREADY];
    // External carrier blocked by second select line
    if (!q.comm_ctrl[CC_PSEL1]) begin
      ext_cd_n = ext_set_carrier_n_i;
    end
    next_q.carrier_n = int_set_carrier_n_i & ext_cd_n;
    // Multiplexer steering of send permission
    case (port)
      PORT_LINE: next_q.permit_n = int_set_send_permit_n_i;
      PORT_HOST: next_q.permit_n = host_send_permit_n_i;
      PORT_LOOP: next_q.permit_n = 1'b0;
      default: next_q.permit_n = 1'b1;
    endcase
    // Speed forcing from either indicator
    next_q.forced = !ext_set_speed_force_n_i || !int_set_speed_force_n_i;
    next_q.speed = next_q.forced ? SPD_1200 : cfg_speed;
    next_q.spd_sel_n = !(cfg_speed > SPD_600);
  end

  // ==========================================
  // State register
  // ==========================================
  // Synchronous active-low reset
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.line_ctrl <= LINE_CTRL_RST;
      q.comm_ctrl <= COMM_CTRL_RST;
      q.wr_sel_n <= 4'hf;
      q.rd_sel_n <= 4'hf;
      q.sc_wr_n <= 1'b1;
      q.sc_rd_n <= 1'b1;
      q.rx_irq_n <= 1'b1;
      q.tx_irq_n <= 1'b1;
      q.term_ready_n <= 1'b1;
      q.spd_sel_n <= 1'b1;
      q.carrier_n <= 1'b1;
      q.permit_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign reg_rdata_o = q.rdata;
  assign ctrl_wr_sel_n_o = q.wr_sel_n;
  assign ctrl_rd_sel_n_o = q.rd_sel_n;
  assign sc_reg_o = q.sc_reg;
  assign sc_wr_n_o = q.sc_wr_n;
  assign sc_rd_n_o = q.sc_rd_n;
  assign host_rx_irq_n_o = q.rx_irq_n;
  assign host_tx_irq_n_o = q.tx_irq_n;
  assign host_term_ready_n_o = q.term_ready_n;
  assign high_rate_select_n_o = q.spd_sel_n;
  assign char_length_sel_o = q.line_ctrl[LC_CHAR9];
  assign standard_select_o = q.line_ctrl[LC_STD_HI];
  assign line_usage_sel_n_o = q.line_ctrl[LC_VOICE];
  assign originate_answer_sel_o = q.line_ctrl[LC_ANSWER];
  assign offhook_drive_o = q.line_ctrl[LC_OFFHOOK];
  assign merged_carrier_n_o = q.carrier_n;
  assign send_permit_n_o = q.permit_n;
  assign port_select0_o = q.comm_ctrl[CC_PSEL0];
  assign port_select1_o = q.comm_ctrl[CC_PSEL1];
  assign eff_speed_o = q.speed;
endmodule
`default_nettype wire

// File: sim/comm_glue_assertions.sv
// Port-level checker for the communication glue block.
// Assumes one clock, mclk_i, and a synchronous active-low reset.
`default_nettype none
module comm_glue_checker
  import comm_glue_pkg::*;
(
  input wire logic mclk_i, rst_b_i, reg_wr_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic latched_addr_bit1_i, latched_addr_bit2_i, latched_addr_bit3_i, latched_addr_bit4_i,
  input wire logic latched_addr_bit5_i, low_byte_write_n_i, decoder_enable_n_i, sc_write_n_i,
  input wire logic serial_ctrl_select_n_i, ext_set_carrier_n_i, int_set_carrier_n_i, int_set_send_permit_n_i,
  input wire logic ext_set_speed_force_n_i, int_set_speed_force_n_i, sc_wr_n_o, host_term_ready_n_o,
  input wire logic [3:0] ctrl_wr_sel_n_o, sc_reg_o,
  input wire logic high_rate_select_n_o, char_length_sel_o, standard_select_o, line_usage_sel_n_o,
  input wire logic originate_answer_sel_o, offhook_drive_o, merged_carrier_n_o, send_permit_n_o,
  input wire logic port_select0_o, port_select1_o,
  input wire logic [RXSPD_W-1:0] eff_speed_o
);
  // ==========================================
  // Shared clock and reset
  // ==========================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================
  // Decode, controls and steering
  // ==========================================
  a_ctrl_write_sel: assert property (!decoder_enable_n_i && !low_byte_write_n_i |=>
    ctrl_wr_sel_n_o == ~(4'h1 << $past({latched_addr_bit2_i, latched_addr_bit1_i}))) else $error("ctrl select");
  a_enable_gate: assert property (decoder_enable_n_i |=> ctrl_wr_sel_n_o == 4'hf)
    else $error("ctrl select while disabled");
  a_sc_write_sel: assert property (!sc_write_n_i && !serial_ctrl_select_n_i |=> !sc_wr_n_o &&
    sc_reg_o == $past({latched_addr_bit5_i, latched_addr_bit4_i, latched_addr_bit3_i, latched_addr_bit2_i}))
    else $error("serial select");
  a_term_ready: assert property (reg_wr_i && reg_addr_i == OFF_COMM_CTRL ##1 !reg_wr_i |=>
    host_term_ready_n_o == !$past(reg_wdata_i[CC_TREADY], 2)) else $error("terminal ready");
  a_line_bits: assert property (reg_wr_i && reg_addr_i == OFF_LINE_CTRL |=>
    {offhook_drive_o, originate_answer_sel_o, line_usage_sel_n_o, standard_select_o, char_length_sel_o}
    == $past(reg_wdata_i[4:0])) else $error("line controls");
  a_carrier_merge: assert property (1'b1 |=> merged_carrier_n_o ==
    $past(int_set_carrier_n_i && (port_select1_o || ext_set_carrier_n_i))) else $error("carrier");
  a_permit_line: assert property (port_select0_o && port_select1_o |=>
    send_permit_n_o == $past(int_set_send_permit_n_i)) else $error("send permit");
  a_speed_force: assert property (!(ext_set_speed_force_n_i && int_set_speed_force_n_i) |=>
    eff_speed_o == SPD_1200) else $error("forced speed");
  a_rate_select: assert property ($past(ext_set_speed_force_n_i && int_set_speed_force_n_i) |->
    high_rate_select_n_o == (eff_speed_o <= SPD_600)) else $error("rate select");
endmodule
bind comm_dataset_control_glue comm_glue_checker u_chk (.*);
`default_nettype wire

// File: sim/line_unit_model.sv
// Far-side model: external host set and integral line unit.
// Assumes the bench sets the far side's levels through ctl_i.
`default_nettype none
module line_unit_model #(
  parameter int HOOK_DLY = 3  // Relay settle cycles, at least 2
) (
  input wire logic clk_i,
  input wire logic offhook_drive_i,  // Relay drive from the terminal
  input wire logic [6:0] ctl_i,  // Far-side levels, active low
  output logic [8:0] pins_o  // Hook status, fitted flag, levels
);
  logic [HOOK_DLY-1:0] hook;  // Relay settling pipeline
  // Relay reports off hook only after it has settled
  always_ff @(posedge clk_i) begin
    hook <= {hook[HOOK_DLY-2:0], offhook_drive_i};
  end
  // Unit always fitted; handshake and carrier as commanded
  assign pins_o = {hook[HOOK_DLY-1], 1'b0, ctl_i};
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the communication glue block.
// Assumes the package, far-side model and checker compile first.
`default_nettype none
module tb_top
  import comm_glue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Signals, named as the block's ports
  // ==========================================
  logic mclk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, host_rx_ready_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, v;
  logic latched_addr_bit1_i = 1'b0, latched_addr_bit2_i = 1'b0, latched_addr_bit3_i = 1'b0;
  logic latched_addr_bit4_i = 1'b0, latched_addr_bit5_i = 1'b0, host_tx_empty_i = 1'b0;
  logic low_byte_write_n_i = 1'b1, ctrl_read_strobe_n_i = 1'b1, decoder_enable_n_i = 1'b1;
  logic sc_write_n_i = 1'b1, sc_read_n_i = 1'b1, serial_ctrl_select_n_i = 1'b1;
  logic [6:0] levels_n = 7'h7f;  // Far side idle
  wire logic [8:0] pins;
  wire logic ext_set_carrier_n_i = pins[0], int_set_carrier_n_i = pins[1], host_send_permit_n_i = pins[2];
  wire logic int_set_send_permit_n_i = pins[3], host_set_ready_n_i = pins[4], ext_set_speed_force_n_i = pins[5];
  wire logic int_set_speed_force_n_i = pins[6], int_set_installed_n_i = pins[7], int_set_offhook_i = pins[8];
  wire logic [7:0] reg_rdata_o;
  wire logic [3:0] ctrl_wr_sel_n_o, ctrl_rd_sel_n_o, sc_reg_o;
  wire logic [2:0] eff_speed_o;
  wire logic sc_wr_n_o, sc_rd_n_o, host_rx_irq_n_o, host_tx_irq_n_o, host_term_ready_n_o, high_rate_select_n_o;
  wire logic char_length_sel_o, standard_select_o, line_usage_sel_n_o, originate_answer_sel_o, offhook_drive_o;
  wire logic merged_carrier_n_o, send_permit_n_o, port_select0_o, port_select1_o;
  int n_errors = 0, comparisons = 0;
  // Rows: psel1, psel0, int permit, host permit, int carrier, ext carrier, carrier, permit
  logic [7:0] rows [6] = '{8'hda, 8'h28, 8'h1f, 8'he5, 8'hba, 8'h49};
  comm_dataset_control_glue uut (.*);
  line_unit_model #(.HOOK_DLY(3)) far_end (.clk_i(mclk_i), .offhook_drive_i(offhook_drive_o), .ctl_i(levels_n),
    .pins_o(pins));
  always #10 mclk_i = ~mclk_i;
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (3000) @(posedge mclk_i);
    n_errors++;
    stop_test();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    settle(0);
    check({host_term_ready_n_o, high_rate_select_n_o, sc_wr_n_o, sc_rd_n_o, host_rx_irq_n_o, eff_speed_o},
      8'hf8);
    check({ctrl_wr_sel_n_o, ctrl_rd_sel_n_o}, 8'hff);
    $display("reset test done");
    foreach (rows[i]) begin
      reg_write(OFF_COMM_CTRL, {6'h00, rows[i][7:6]});
      levels_n[3:0] <= rows[i][5:2];
      settle(2);
      check(merged_carrier_n_o, rows[i][1]);
      check(send_permit_n_o, rows[i][0]);
      check({port_select1_o, port_select0_o}, rows[i][7:6]);
    end
    $display("steering test done");
    for (int s = 0; s < 8; s++) begin
      reg_write(OFF_COMM_CTRL, {1'b0, s[2:0], 4'h4});
      settle(2);
      check(eff_speed_o, s[2:0]);
      check(high_rate_select_n_o, s[2:0] <= SPD_600);
      check(host_term_ready_n_o, 1'b0);
    end
    for (int f = 5; f < 7; f++) begin
      @(posedge mclk_i);
      levels_n[f] <= 1'b0;
      settle(2);
      check(eff_speed_o, SPD_1200);
      check(high_rate_select_n_o, 1'b0);
      @(posedge mclk_i);
      levels_n[f] <= 1'b1;
    end
    reg_write(OFF_COMM_CTRL, 8'h00);
    settle(2);
    check(host_term_ready_n_o, 1'b1);
    $display("speed test done");
    for (int k = 0; k < 2; k++) begin
      reg_write(OFF_LINE_CTRL, k ? 8'h15 : 8'h0a);
      settle(0);
      check({offhook_drive_o, originate_answer_sel_o, line_usage_sel_n_o, standard_select_o, char_length_sel_o},
        k ? 8'h15 : 8'h0a);
    end
    @(posedge mclk_i);
    levels_n[4] <= 1'b0;
    settle(5);
    reg_read(OFF_STATUS);
    check(v, 8'h1f);
    reg_read(OFF_LINE_CTRL);
    check(v, 8'h15);
    reg_read(8'h40);
    check(v, 8'h00);
    @(posedge mclk_i);
    host_rx_ready_i <= 1'b1;
    host_tx_empty_i <= 1'b1;
    settle(1);
    check({host_rx_irq_n_o, host_tx_irq_n_o}, 8'h00);
    @(posedge mclk_i);
    host_rx_ready_i <= 1'b0;
    settle(1);
    check({host_rx_irq_n_o, host_tx_irq_n_o}, 8'h02);
    $display("status test done");
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk_i);
      {latched_addr_bit2_i, latched_addr_bit1_i} <= j[1:0];
      decoder_enable_n_i <= 1'b0;
      low_byte_write_n_i <= j[0];
      ctrl_read_strobe_n_i <= !j[0];
      settle(1);
      check({ctrl_wr_sel_n_o, ctrl_rd_sel_n_o}, j[0] ? {4'hf, ~(4'h1 << j)} : {~(4'h1 << j), 4'hf});
    end
    reg_read(OFF_STRB_STAT);
    check(v, 8'h80);
    @(posedge mclk_i);
    decoder_enable_n_i <= 1'b1;
    settle(1);
    check({ctrl_wr_sel_n_o, ctrl_rd_sel_n_o}, 8'hff);
    @(posedge mclk_i);
    {latched_addr_bit5_i, latched_addr_bit4_i, latched_addr_bit3_i, latched_addr_bit2_i} <= 4'ha;
    serial_ctrl_select_n_i <= 1'b0;
    sc_write_n_i <= 1'b0;
    settle(1);
    check({sc_reg_o, sc_wr_n_o, sc_rd_n_o}, 8'h29);
    @(posedge mclk_i);
    sc_write_n_i <= 1'b1;
    sc_read_n_i <= 1'b0;
    settle(1);
    check({sc_reg_o, sc_wr_n_o, sc_rd_n_o}, 8'h2a);
    $display("decode test done");
    stop_test();
  end
endmodule
`default_nettype wire
